// *** rtl/erec_pkg.sv ***
// Constants and types shared by the event-recorder entry encoder.
// Overview of operation
// - Low nibble of type byte gives kind
// - Bit 7 set only for scan entries
// - Last scan entry also sets bit 6
// - Scan request bit starts full object scan
// - Optional start-up scan after reset, default off
// - Scan fetches sequentially, stamped at response time
// - Value word holds value after change
// - Single-point value: 1 on, 0 off
// - Double-point: 2 on, 1 off, 3/0 intermediate
// - Tap: 1..62 valid, 63 invalid, 128 unrouted
// - Statistic signed; 8000 hex when invalid/overflow
// - Entry carries millisecond-to-year change time
// - Clock status ORs 10, 20, 40 hex flags
// - Register type FF when entry not valid
package erec_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_HDR    = 8'h0c;
    localparam logic [7:0] OFF_VALUE  = 8'h10;
    localparam logic [7:0] OFF_TIME0  = 8'h14;
    localparam logic [7:0] OFF_TIME1  = 8'h18;
    // Control register bits
    localparam int SCAN_REQ_BIT = 0;
    localparam int ENTRY_ACK_BIT = 1;
    localparam int ENTRY_VALID_BIT = 1;
    // Status and mask bits
    localparam int IRQ_W = 2;
    localparam int IRQ_ENTRY = 0;
    localparam int IRQ_SCAN_DONE = 1;
    // Indication-type byte
    localparam int ORIGIN_BIT = 7;
    localparam int COMPLETE_BIT = 6;
    localparam logic [1:0] RESERVED_VAL = 2'h0;
    localparam logic [3:0] KIND_SP   = 4'h1;
    localparam logic [3:0] KIND_DP   = 4'h2;
    localparam logic [3:0] KIND_TAP  = 4'h3;
    localparam logic [3:0] KIND_STAT = 4'h4;
    // Value codes
    localparam logic [15:0] SP_ON   = 16'h0001;
    localparam logic [15:0] SP_OFF  = 16'h0000;
    localparam logic [15:0] DP_NA   = 16'h0000;
    localparam logic [15:0] DP_OFF  = 16'h0001;
    localparam logic [15:0] DP_ON   = 16'h0002;
    localparam logic [15:0] DP_MID  = 16'h0003;
    localparam logic [5:0]  TAP_MAX = 6'h3e;
    localparam logic [15:0] TAP_BAD = 16'h003f;
    localparam logic [15:0] TAP_UNROUTED = 16'h0080;
    localparam logic [15:0] STAT_BAD = 16'h8000;
    // Clock status flags and empty-entry register type
    localparam logic [7:0] CLK_DST  = 8'h10;
    localparam logic [7:0] CLK_FAIL = 8'h20;
    localparam logic [7:0] CLK_INV  = 8'h40;
    localparam logic [7:0] REG_TYPE_NONE = 8'hff;

    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_AWAIT} scan_state_t;
endpackage

// *** rtl/type_encoder.sv ***
// Builds the indication-type byte and the clock status byte.
`timescale 1ns/100ps
module type_encoder (
    // Entry source
    input  wire logic [3:0] kind,
    input  wire logic       from_scan,
    input  wire logic       last,
    // Clock flags
    input  wire logic       dst,
    input  wire logic       fail,
    input  wire logic       inv,
    // Encoded bytes
    output logic      [7:0] type_byte,
    output logic      [7:0] clk_byte
);
    always_comb begin
        type_byte = {from_scan, from_scan & last,
                     erec_pkg::RESERVED_VAL, kind};
        clk_byte  = (dst ? erec_pkg::CLK_DST : 8'h00)
                  | (fail ? erec_pkg::CLK_FAIL : 8'h00)
                  | (inv ? erec_pkg::CLK_INV : 8'h00);
    end
endmodule

// *** rtl/value_encoder.sv ***
// Encodes the entry value word from the raw source value.
`timescale 1ns/100ps
module value_encoder (
    // Raw source
    input  wire logic [3:0]  kind,
    input  wire logic [15:0] raw,
    input  wire logic        invalid,
    input  wire logic        unrouted,
    // Encoded word
    output logic      [15:0] word
);
    always_comb begin
        word = raw;
        unique case (kind)
            erec_pkg::KIND_SP:
                word = raw[0] ? erec_pkg::SP_ON : erec_pkg::SP_OFF;
            erec_pkg::KIND_DP: begin
                // raw[1] is the on contact, raw[0] the off contact
                unique case (raw[1:0])
                    2'h2:    word = erec_pkg::DP_ON;
                    2'h1:    word = erec_pkg::DP_OFF;
                    2'h3:    word = erec_pkg::DP_MID;
                    default: word = erec_pkg::DP_NA;
                endcase
            end
            erec_pkg::KIND_TAP: begin
                if (unrouted) begin
                    word = erec_pkg::TAP_UNROUTED;
                end else if (invalid || raw[5:0] == 6'h00
                             || raw[5:0] > erec_pkg::TAP_MAX) begin
                    word = erec_pkg::TAP_BAD;
                end else begin
                    word = {10'h000, raw[5:0]};
                end
            end
            erec_pkg::KIND_STAT:
                word = invalid ? erec_pkg::STAT_BAD : raw;
            default: word = raw;
        endcase
    end
endmodule

// *** rtl/event_record_entry_encoder.sv ***
// Event-recorder entry encoder with general scan and APB registers.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module event_record_entry_encoder #(
    parameter int NUM_OBJ = 16
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Shared source data
    input  wire logic [3:0]  src_kind,
    input  wire logic [15:0] src_value,
    input  wire logic        src_invalid,
    input  wire logic        src_unrouted,
    input  wire logic [7:0]  src_reg_type,
    // Spontaneous events
    input  wire logic        evt_valid,
    output logic             evt_ready,
    // Scan fetch
    output logic             fetch_req,
    output logic [$clog2(NUM_OBJ)-1:0] fetch_index,
    input  wire logic        fetch_ack,
    // Time of day
    input  wire logic [15:0] time_ms,
    input  wire logic [7:0]  time_min,
    input  wire logic [7:0]  time_hour,
    input  wire logic [7:0]  time_day,
    input  wire logic [7:0]  time_month,
    input  wire logic [7:0]  time_year,
    input  wire logic        clk_dst,
    input  wire logic        clk_fail,
    input  wire logic        clk_inv,
    // Strap and interrupt
    input  wire logic        startup_scan_en,
    output logic             irq
);
    localparam int IW = $clog2(NUM_OBJ);
    localparam int IRQ_W_L = erec_pkg::IRQ_W;

    erec_pkg::scan_state_t state, next_state;
    logic [IW-1:0] next_index;
    logic          next_fetch_req, started, next_started;
    logic          entry_valid, next_entry_valid, next_evt_ready;
    logic [7:0]    entry_reg_type, next_reg_type;
    logic [7:0]    entry_type, next_type, entry_clk, next_clk;
    logic [15:0]   entry_value, next_value, entry_ms, next_ms;
    logic [7:0]    entry_min, next_min, entry_hour, next_hour;
    logic [7:0]    entry_day, next_day, entry_month, next_month;
    logic [7:0]    entry_year, next_year;
    logic [IRQ_W_L-1:0] status, next_status, mask, next_mask;
    logic          next_irq, next_pready, next_pslverr;
    logic [31:0]   next_prdata;
    logic [7:0]    type_byte, clk_byte;
    logic [15:0]   val_word;
    logic          acc, wr, ctrl_wr, load_scan, load_evt, load;
    logic          scan_last, start_scan, mapped;
    logic [31:0]   rd_word;

    assign acc       = psel & penable & pready;
    assign wr        = acc & pwrite;
    assign ctrl_wr   = wr && paddr == erec_pkg::OFF_CTRL;
    assign load_scan = fetch_req & fetch_ack;
    assign load_evt  = evt_valid & evt_ready;
    assign load      = load_scan | load_evt;
    assign scan_last = fetch_index == IW'(NUM_OBJ - 1);
    // Start-up option is a strap caught once after reset
    assign start_scan = (ctrl_wr && pwdata[erec_pkg::SCAN_REQ_BIT])
                      || (!started && startup_scan_en);

    type_encoder u_type (
        .kind      (src_kind),
        .from_scan (load_scan),
        .last      (scan_last),
        .dst       (clk_dst),
        .fail      (clk_fail),
        .inv       (clk_inv),
        .type_byte (type_byte),
        .clk_byte  (clk_byte)
    );

    value_encoder u_val (
        .kind     (src_kind),
        .raw      (src_value),
        .invalid  (src_invalid),
        .unrouted (src_unrouted),
        .word     (val_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Scan sequencer
    always_comb begin
        next_state   = state;
        next_index   = fetch_index;
        next_started = 1'b1;
        unique case (state)
            erec_pkg::S_IDLE: begin
                if (start_scan) begin
                    next_state = erec_pkg::S_ISSUE;
                    next_index = '0;
                end
            end
            erec_pkg::S_ISSUE: begin
                // One fetch at a time, only into an empty entry
                if (!entry_valid) begin
                    next_state = erec_pkg::S_AWAIT;
                end
            end
            erec_pkg::S_AWAIT: begin
                if (fetch_ack) begin
                    if (scan_last) begin
                        next_state = erec_pkg::S_IDLE;
                    end else begin
                        next_state = erec_pkg::S_ISSUE;
                        next_index = fetch_index + IW'(1);
                    end
                end
            end
        endcase
        next_fetch_req = next_state == erec_pkg::S_AWAIT;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= erec_pkg::S_IDLE;
            fetch_index <= '0;
            fetch_req   <= 1'b0;
            started     <= 1'b0;
        end else begin
            state       <= next_state;
            fetch_index <= next_index;
            fetch_req   <= next_fetch_req;
            started     <= next_started;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry holding register
    always_comb begin
        next_entry_valid = entry_valid;
        next_reg_type    = entry_reg_type;
        next_type        = entry_type;
        next_value       = entry_value;
        next_clk         = entry_clk;
        next_ms          = entry_ms;
        next_min         = entry_min;
        next_hour        = entry_hour;
        next_day         = entry_day;
        next_month       = entry_month;
        next_year        = entry_year;
        if (ctrl_wr && pwdata[erec_pkg::ENTRY_ACK_BIT]) begin
            next_entry_valid = 1'b0;
            next_reg_type    = erec_pkg::REG_TYPE_NONE;
        end
        if (load) begin
            next_entry_valid = 1'b1;
            next_reg_type    = src_reg_type;
            next_type        = type_byte;
            next_value       = val_word;
            next_clk         = clk_byte;
            // Stamp is the moment the value arrived here
            next_ms          = time_ms;
            next_min         = time_min;
            next_hour        = time_hour;
            next_day         = time_day;
            next_month       = time_month;
            next_year        = time_year;
        end
        // Events wait while a scan runs, so entries never interleave
        next_evt_ready = !next_entry_valid
                       && next_state == erec_pkg::S_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_valid    <= 1'b0;
            entry_reg_type <= erec_pkg::REG_TYPE_NONE;
            entry_type     <= 8'h00;
            entry_value    <= 16'h0000;
            entry_clk      <= 8'h00;
            entry_ms       <= 16'h0000;
            entry_min      <= 8'h00;
            entry_hour     <= 8'h00;
            entry_day      <= 8'h00;
            entry_month    <= 8'h00;
            entry_year     <= 8'h00;
            evt_ready      <= 1'b0;
        end else begin
            entry_valid    <= next_entry_valid;
            entry_reg_type <= next_reg_type;
            entry_type     <= next_type;
            entry_value    <= next_value;
            entry_clk      <= next_clk;
            entry_ms       <= next_ms;
            entry_min      <= next_min;
            entry_hour     <= next_hour;
            entry_day      <= next_day;
            entry_month    <= next_month;
            entry_year     <= next_year;
            evt_ready      <= next_evt_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and APB slave
    always_comb begin
        logic [IRQ_W_L-1:0] set, clr;
        set = '0;
        clr = '0;
        set[erec_pkg::IRQ_ENTRY]     = load;
        set[erec_pkg::IRQ_SCAN_DONE] = load_scan & scan_last;
        if (wr && paddr == erec_pkg::OFF_STATUS) begin
            clr = pwdata[IRQ_W_L-1:0];
        end
        // Set beats a simultaneous clear
        next_status = (status & ~clr) | set;
        next_mask   = mask;
        if (wr && paddr == erec_pkg::OFF_MASK) begin
            next_mask = pwdata[IRQ_W_L-1:0];
        end
        next_irq = |(next_status & next_mask);

        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            erec_pkg::OFF_CTRL: begin
                rd_word[erec_pkg::SCAN_REQ_BIT] =
                    state != erec_pkg::S_IDLE;
                rd_word[erec_pkg::ENTRY_VALID_BIT] = entry_valid;
            end
            erec_pkg::OFF_STATUS: rd_word[IRQ_W_L-1:0] = status;
            erec_pkg::OFF_MASK:   rd_word[IRQ_W_L-1:0] = mask;
            erec_pkg::OFF_HDR:
                rd_word = {entry_reg_type, 16'h0000, entry_type};
            erec_pkg::OFF_VALUE:  rd_word = {16'h0000, entry_value};
            erec_pkg::OFF_TIME0:
                rd_word = {entry_hour, entry_min, entry_ms};
            erec_pkg::OFF_TIME1:
                rd_word = {entry_clk, entry_year, entry_month, entry_day};
            default: mapped = 1'b0;
        endcase
        // One wait state: answer comes on the second access cycle
        next_pready  = psel & penable & ~pready;
        next_prdata  = (next_pready && !pwrite) ? rd_word : 32'h0000_0000;
        next_pslverr = next_pready & ~mapped;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status  <= '0;
            mask    <= '0;
            irq     <= 1'b0;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            status  <= next_status;
            mask    <= next_mask;
            irq     <= next_irq;
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_scan_write;
        ctrl_wr && pwdata[erec_pkg::SCAN_REQ_BIT]
            && state == erec_pkg::S_IDLE;
    endsequence

    sequence s_first_fetch;
        state == erec_pkg::S_ISSUE && fetch_index == '0;
    endsequence

    property p_kind;
        load |=> entry_type[3:0] == $past(src_kind);
    endproperty
    a_kind: assert property (p_kind)
        else $error("kind nibble wrong");

    property p_reserved;
        entry_valid |-> entry_type[5:4] == erec_pkg::RESERVED_VAL;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits set");

    property p_origin;
        load |=> entry_type[erec_pkg::ORIGIN_BIT] == $past(load_scan);
    endproperty
    a_origin: assert property (p_origin)
        else $error("scan origin flag wrong");

    property p_complete;
        load_scan |=> entry_type[erec_pkg::COMPLETE_BIT]
            == $past(scan_last) && entry_type[erec_pkg::ORIGIN_BIT];
    endproperty
    a_complete: assert property (p_complete)
        else $error("scan complete flag wrong");

    property p_scan_req;
        s_scan_write |=> s_first_fetch ##[1:2] fetch_req || entry_valid;
    endproperty
    a_scan_req: assert property (p_scan_req)
        else $error("scan request not started");

    property p_startup;
        !started && startup_scan_en |=> s_first_fetch;
    endproperty
    a_startup: assert property (p_startup)
        else $error("start-up scan not started");

    property p_stamp;
        load_scan |=> entry_ms == $past(time_ms)
            && entry_hour == $past(time_hour);
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("scan stamp wrong");

    property p_date;
        load |=> entry_year == $past(time_year)
            && entry_day == $past(time_day) && entry_valid;
    endproperty
    a_date: assert property (p_date)
        else $error("entry date wrong");

    property p_sp;
        load && src_kind == erec_pkg::KIND_SP |=> entry_value
            == ($past(src_value[0]) ? erec_pkg::SP_ON : erec_pkg::SP_OFF);
    endproperty
    a_sp: assert property (p_sp)
        else $error("single-point value wrong");

    property p_dp;
        load && src_kind == erec_pkg::KIND_DP && src_value[1:0] == 2'h2
            |=> entry_value == erec_pkg::DP_ON;
    endproperty
    a_dp: assert property (p_dp)
        else $error("double-point on wrong");

    property p_tap;
        load && src_kind == erec_pkg::KIND_TAP && src_unrouted
            |=> entry_value == erec_pkg::TAP_UNROUTED;
    endproperty
    a_tap: assert property (p_tap)
        else $error("unrouted tap value wrong");

    property p_stat;
        load && src_kind == erec_pkg::KIND_STAT && src_invalid
            |=> entry_value == erec_pkg::STAT_BAD;
    endproperty
    a_stat: assert property (p_stat)
        else $error("invalid statistic value wrong");

    property p_clk;
        load |=> entry_clk[3:0] == 4'h0 && entry_clk[7] == 1'b0
            && entry_clk[4] == $past(clk_dst)
            && entry_clk[6] == $past(clk_inv);
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock status wrong");

    property p_none;
        !entry_valid |-> entry_reg_type == erec_pkg::REG_TYPE_NONE;
    endproperty
    a_none: assert property (p_none)
        else $error("empty entry not marked");
endmodule

// *** tb/obj_source.sv ***
// Behavioural model of the objects feeding the recorder's fetch and events.
`timescale 1ns/100ps
module obj_source #(
    parameter int IW = 2
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Scan fetch
    input  wire logic          fetch_req,
    input  wire logic [IW-1:0] fetch_index,
    output logic               fetch_ack,
    input  wire logic          slow,
    // Spontaneous events
    input  wire logic          ev_go,
    input  wire logic [3:0]    ev_kind,
    input  wire logic [15:0]   ev_raw,
    input  wire logic          ev_inv,
    input  wire logic          ev_unr,
    output logic               evt_valid,
    input  wire logic          evt_ready,
    // Shared source data
    output logic [3:0]         src_kind,
    output logic [15:0]        src_value,
    output logic               src_invalid,
    output logic               src_unrouted,
    output logic [7:0]         src_reg_type
);
    logic [1:0]  wait_cnt;
    logic [15:0] last;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_ack <= 1'b0;
            evt_valid <= 1'b0;
            wait_cnt  <= 2'h0;
            last      <= 16'h0000;
        end else begin
            // One object answered at a time, late when slow
            fetch_ack <= fetch_req && !fetch_ack
                         && (wait_cnt == (slow ? 2'h3 : 2'h0));
            wait_cnt  <= (fetch_req && !fetch_ack) ? wait_cnt + 2'h1 : 2'h0;
            if (ev_go) begin
                evt_valid <= 1'b1;
            end else if (evt_valid && evt_ready) begin
                evt_valid <= 1'b0;
            end
            last <= src_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle data flips every cycle so stale values never pass
    always_comb begin
        src_kind     = ~last[3:0];
        src_value    = ~last;
        src_invalid  = last[0];
        src_unrouted = ~last[0];
        src_reg_type = ~last[7:0];
        if (fetch_ack) begin
            src_kind     = 4'(fetch_index) + 4'h1;
            src_invalid  = 1'b0;
            src_unrouted = 1'b0;
            src_reg_type = 8'h04;
            case (fetch_index)
                0:       src_value = 16'h0001;
                1:       src_value = 16'h0002;
                2:       src_value = 16'h0005;
                default: src_value = 16'hfff0;
            endcase
        end else if (evt_valid) begin
            src_kind     = ev_kind;
            src_value    = ev_raw;
            src_invalid  = ev_inv;
            src_unrouted = ev_unr;
            src_reg_type = 8'h01;
        end
    end
endmodule

// *** tb/event_record_entry_encoder_tb.sv ***
// Self-checking bench for the event-recorder entry encoder.
`timescale 1ns/100ps
module event_record_entry_encoder_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, evt_valid, evt_ready;
    logic        fetch_req, fetch_ack, src_invalid, src_unrouted;
    logic [1:0]  fetch_index;
    logic [3:0]  src_kind;
    logic [15:0] src_value;
    logic [7:0]  src_reg_type;
    logic        startup_scan_en = 1'b0;
    logic        slow = 1'b0;
    logic        ev_go = 1'b0;
    logic [3:0]  ev_kind = 4'h0;
    logic [15:0] ev_raw = 16'h0;
    logic        ev_inv = 1'b0;
    logic        ev_unr = 1'b0;
    logic [15:0] time_ms = 16'h0;
    logic [7:0]  time_min = 8'h1e;
    logic [7:0]  time_hour = 8'h0c;
    logic [7:0]  time_day = 8'h09;
    logic [7:0]  time_month = 8'h05;
    logic [7:0]  time_year = 8'h7b;
    logic        clk_dst = 1'b0;
    logic        clk_fail = 1'b0;
    logic        clk_inv = 1'b0;
    logic [15:0] stamp = 16'h0;
    logic [31:0] rq;
    logic        re;
    int          fails = 0;
    int          compares = 0;
    // Kind, invalid, unrouted, raw value, expected word
    logic [43:0] ev_tab [12] = '{
        44'h1_0_0_0001_0001, 44'h1_0_0_0000_0000, 44'h2_0_0_0002_0002,
        44'h2_0_0_0001_0001, 44'h2_0_0_0003_0003, 44'h2_0_0_0000_0000,
        44'h3_0_0_003e_003e, 44'h3_0_0_003f_003f, 44'h3_1_0_0005_003f,
        44'h3_0_1_0005_0080, 44'h4_0_0_8001_8001, 44'h4_1_0_1234_8000};
    logic [15:0] sc_val [4] = '{16'h0001, 16'h0002, 16'h0005, 16'hfff0};

    ////////////////////////////////////////////////////////////////////////
    always #5 pclk = ~pclk;
    always @(posedge pclk) time_ms <= time_ms + 16'h0001;
    // Time of the edge at which the entry source is taken
    always @(posedge pclk)
        if ((fetch_req && fetch_ack) || (evt_valid && evt_ready))
            stamp <= time_ms;

    event_record_entry_encoder #(.NUM_OBJ(4)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_kind(src_kind),
        .src_value(src_value), .src_invalid(src_invalid),
        .src_unrouted(src_unrouted), .src_reg_type(src_reg_type),
        .evt_valid(evt_valid), .evt_ready(evt_ready),
        .fetch_req(fetch_req), .fetch_index(fetch_index),
        .fetch_ack(fetch_ack), .time_ms(time_ms), .time_min(time_min),
        .time_hour(time_hour), .time_day(time_day),
        .time_month(time_month), .time_year(time_year),
        .clk_dst(clk_dst), .clk_fail(clk_fail), .clk_inv(clk_inv),
        .startup_scan_en(startup_scan_en), .irq(irq));

    obj_source #(.IW(2)) src (
        .pclk(pclk), .presetn(presetn), .fetch_req(fetch_req),
        .fetch_index(fetch_index), .fetch_ack(fetch_ack), .slow(slow),
        .ev_go(ev_go), .ev_kind(ev_kind), .ev_raw(ev_raw),
        .ev_inv(ev_inv), .ev_unr(ev_unr), .evt_valid(evt_valid),
        .evt_ready(evt_ready), .src_kind(src_kind),
        .src_value(src_value), .src_invalid(src_invalid),
        .src_unrouted(src_unrouted), .src_reg_type(src_reg_type));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Idle cycle at the end keeps back-to-back calls from clashing
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rq, exp);
    endtask

    task automatic wait_entry;
        do begin
            apb(1'b0, erec_pkg::OFF_CTRL, 32'h0);
        end while (rq[erec_pkg::ENTRY_VALID_BIT] !== 1'b1);
    endtask

    task automatic entry(input logic [7:0] typ, input logic [7:0] rt,
                         input logic [15:0] val, input logic [7:0] cs);
        rd(erec_pkg::OFF_HDR, {rt, 16'h0000, typ});
        rd(erec_pkg::OFF_VALUE, {16'h0000, val});
        rd(erec_pkg::OFF_TIME0, {time_hour, time_min, stamp});
        rd(erec_pkg::OFF_TIME1, {cs, time_year, time_month, time_day});
        apb(1'b1, erec_pkg::OFF_CTRL, 32'h2);
    endtask

    task automatic do_scan;
        for (int j = 0; j < 4; j++) begin
            wait_entry();
            check(rq[erec_pkg::SCAN_REQ_BIT], j != 3);
            entry({1'b1, j == 3, 2'h0, 4'(j + 1)}, 8'h04, sc_val[j], 8'h70);
        end
        rd(erec_pkg::OFF_STATUS, 32'h3);
        apb(1'b1, erec_pkg::OFF_STATUS, 32'h3);
    endtask

    task automatic summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, erec_pkg::OFF_HDR, 32'h0);
        check(rq[31:24], 8'hff);
        check(evt_ready, 1'b1);
        rd(erec_pkg::OFF_MASK, 32'h0);
        rd(8'h1c, 32'h0);
        check(re, 1'b1);
        for (int i = 0; i < 12; i++) begin
            ev_kind <= ev_tab[i][43:40];
            ev_inv <= ev_tab[i][36];
            ev_unr <= ev_tab[i][32];
            ev_raw <= ev_tab[i][31:16];
            {clk_inv, clk_fail, clk_dst} <= 3'(i);
            ev_go <= 1'b1;
            @(posedge pclk);
            ev_go <= 1'b0;
            wait_entry();
            // First event runs with the interrupt masked off
            check(irq, i > 0);
            if (i == 0) begin
                apb(1'b1, erec_pkg::OFF_MASK, 32'h1);
            end
            rd(erec_pkg::OFF_STATUS, 32'h1);
            apb(1'b1, erec_pkg::OFF_STATUS, 32'h1);
            check(irq, 1'b0);
            entry({4'h0, ev_tab[i][43:40]}, 8'h01, ev_tab[i][15:0], {1'b0, 3'(i), 4'h0});
        end
        {clk_inv, clk_fail, clk_dst} <= 3'h7;
        slow <= 1'b1;
        apb(1'b1, erec_pkg::OFF_CTRL, 32'h1);
        do_scan();
        // Second reset with the start-up scan strap set
        presetn <= 1'b0;
        startup_scan_en <= 1'b1;
        slow <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        startup_scan_en <= 1'b0;
        do_scan();
        summarize();
    end

    initial begin
        #300000;
        fails++;
        summarize();
    end
endmodule
